/* File: fpl_top.sv */
// Fan PWM generator with spin-up and two temperature loops
// Notes on behaviour
// R1 - Grounded strap picks high range, else low
// R2 - Reset frequency code gives 25 kHz / 30 Hz
// R3 - PWM timed from 3.2 MHz timebase
// R4 - Spin-up drives full duty for chosen time
// R5 - Spin-up time ignored while disable set
// R6 - Floor duty at 0x21, resets 0x55
// R7 - Local loop at/below threshold gives floor
// R8 - Local threshold bits 7:3, 4 degree steps
// R9 - Local register 0x24 resets to 0x41
// R10 - Slope codes 0-4 give 32..2 per degree
// R11 - Remote register 0x25 resets to 0x61
// R12 - Remote loop at/below threshold gives floor
// R13 - Remote slope coded like local slope
// R14 - Fan register 0x20 resets 0x1D, fields
// R15 - Frequency codes map to listed frequencies
// R16 - Disable bit set turns spin-up off
// R17 - Above threshold floor plus slope, saturate
// R18 - Slope codes 5-7 act as 2
module fpl_top #(
	parameter int P_SPIN_UNIT_CYC = fpl_pkg::SPIN_UNIT_CYC
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_reset,
	input  wire logic       i_high_range_n,
	input  wire logic [7:0] i_local_temp,
	input  wire logic [7:0] i_remote_temp,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	output logic      [7:0] o_reg_rdata,
	output logic            o_pwm,
	output logic      [7:0] o_duty,
	output logic            o_spinup_active,
	output logic            o_high_range
);
	localparam int UNIT_W = 24;

	if (P_SPIN_UNIT_CYC < 1 || P_SPIN_UNIT_CYC > (1 << UNIT_W)) begin : g_chk
		$error("P_SPIN_UNIT_CYC out of range");
	end

	typedef struct packed {
		logic                         strap_s1;
		logic                         strap_s2;
		logic                         high_range;
		logic [7:0]                   fan_char;
		logic [7:0]                   floor_duty;
		logic [7:0]                   local_cfg;
		logic [7:0]                   remote_cfg;
		logic [7:0]                   rdata;
		logic [16:0]                  tb_acc;
		logic                         tb_tick;
		logic [fpl_pkg::PERIOD_W-1:0] pwm_cnt;
		logic                         pwm;
		logic [UNIT_W-1:0]            unit_cnt;
		logic [6:0]                   spin_cnt;
		fpl_pkg::fpl_spin_e           spin_st;
		logic [7:0]                   duty;
	} fpl_top_s;

	fpl_top_s st_ff;
	fpl_top_s nxt_st;
	fpl_loop_if lp [2] ();
	logic [fpl_pkg::PERIOD_W-1:0] period;
	logic [17:0]                  acc_sum;
	logic                         unit_tick;
	logic                         spin_dis;
	logic [7:0]                   loop_max;
	logic [26:0]                  cnt_scaled;
	logic [26:0]                  duty_scaled;

	// One duty calculator per sensor: 0 local, 1 remote
	for (genvar g = 0; g < 2; g++) begin : g_loop
		// R8 R12 threshold and slope fields
		assign lp[g].temp       = (g == 0) ? i_local_temp : i_remote_temp;
		assign lp[g].thr        = (g == 0) ? st_ff.local_cfg[fpl_pkg::THR_MSB:fpl_pkg::THR_LSB]
			: st_ff.remote_cfg[fpl_pkg::THR_MSB:fpl_pkg::THR_LSB];
		assign lp[g].slope      = (g == 0) ? st_ff.local_cfg[fpl_pkg::SLOPE_MSB:fpl_pkg::SLOPE_LSB]
			: st_ff.remote_cfg[fpl_pkg::SLOPE_MSB:fpl_pkg::SLOPE_LSB];
		assign lp[g].floor_duty = st_ff.floor_duty;
		fpl_duty_calc u_calc (
			.i_core_clk (i_core_clk),
			.i_reset    (i_reset),
			.lp         (lp[g])
		);
	end

	// Next state of the whole block
	always_comb begin
		nxt_st = st_ff;
		// R1 strap synchroniser, grounded means high range
		nxt_st.strap_s1   = i_high_range_n;
		nxt_st.strap_s2   = st_ff.strap_s1;
		nxt_st.high_range = ~st_ff.strap_s2;

		// Register writes; reserved bit stays zero
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				fpl_pkg::ADDR_FAN_CHAR: begin
					nxt_st.fan_char = i_reg_wdata & ~(8'h01 << fpl_pkg::RESERVED_BIT);
				end
				fpl_pkg::ADDR_FLOOR: begin
					nxt_st.floor_duty = i_reg_wdata;
				end
				fpl_pkg::ADDR_LOCAL_CFG: begin
					nxt_st.local_cfg = i_reg_wdata;
				end
				fpl_pkg::ADDR_REMOTE_CFG: begin
					nxt_st.remote_cfg = i_reg_wdata;
				end
				default: begin
				end
			endcase
		end
		// Register reads, unmapped reads as zero
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				fpl_pkg::ADDR_FAN_CHAR:   nxt_st.rdata = st_ff.fan_char;
				fpl_pkg::ADDR_FLOOR:      nxt_st.rdata = st_ff.floor_duty;
				fpl_pkg::ADDR_LOCAL_CFG:  nxt_st.rdata = st_ff.local_cfg;
				fpl_pkg::ADDR_REMOTE_CFG: nxt_st.rdata = st_ff.remote_cfg;
				default:                  nxt_st.rdata = 8'h00;
			endcase
		end

		// R3 fractional divider makes the 3.2 MHz tick
		acc_sum = {1'b0, st_ff.tb_acc} + {1'b0, fpl_pkg::TB_STEP};
		if (acc_sum >= {1'b0, fpl_pkg::TB_MOD}) begin
			nxt_st.tb_acc  = 17'(acc_sum - {1'b0, fpl_pkg::TB_MOD});
			nxt_st.tb_tick = 1'b1;
		end else begin
			nxt_st.tb_acc  = acc_sum[16:0];
			nxt_st.tb_tick = 1'b0;
		end

		// R15 period from range and frequency code
		period = fpl_pkg::fpl_period(st_ff.high_range,
			st_ff.fan_char[fpl_pkg::FREQ_MSB:fpl_pkg::FREQ_LSB]);
		if (st_ff.tb_tick) begin
			if (st_ff.pwm_cnt >= period - 1'b1) begin
				nxt_st.pwm_cnt = '0;
			end else begin
				nxt_st.pwm_cnt = st_ff.pwm_cnt + 1'b1;
			end
		end

		// Spin-up unit timer
		unit_tick = (st_ff.unit_cnt == UNIT_W'(P_SPIN_UNIT_CYC - 1));
		if (unit_tick || st_ff.spin_st != fpl_pkg::SPIN_BOOST) begin
			nxt_st.unit_cnt = '0;
		end else begin
			nxt_st.unit_cnt = st_ff.unit_cnt + 1'b1;
		end

		// R16 R5 spin-up sequencer
		spin_dis = st_ff.fan_char[fpl_pkg::SPINUP_DIS_BIT];
		unique case (st_ff.spin_st)
			fpl_pkg::SPIN_START: begin
				if (spin_dis) begin
					nxt_st.spin_st = fpl_pkg::SPIN_RUN;
				end else begin
					nxt_st.spin_st  = fpl_pkg::SPIN_BOOST;
					nxt_st.spin_cnt = fpl_pkg::SPIN_UNITS[
						st_ff.fan_char[fpl_pkg::STIME_MSB:fpl_pkg::STIME_LSB]];
				end
			end
			fpl_pkg::SPIN_BOOST: begin
				if (spin_dis || (unit_tick && st_ff.spin_cnt == 7'h01)) begin
					nxt_st.spin_st = fpl_pkg::SPIN_RUN;
				end else if (unit_tick) begin
					nxt_st.spin_cnt = st_ff.spin_cnt - 1'b1;
				end
			end
			fpl_pkg::SPIN_RUN: begin
				nxt_st.spin_st = fpl_pkg::SPIN_RUN;
			end
			default: begin
				nxt_st.spin_st = fpl_pkg::SPIN_RUN;
			end
		endcase

		// R4 full duty while boosting, else larger loop duty wins
		loop_max = (lp[0].duty > lp[1].duty) ? lp[0].duty : lp[1].duty;
		if (st_ff.spin_st == fpl_pkg::SPIN_BOOST) begin
			nxt_st.duty = fpl_pkg::DUTY_FULL;
		end else begin
			nxt_st.duty = loop_max;
		end

		// PWM compare: high while count/period below duty/256
		cnt_scaled  = {st_ff.pwm_cnt, 8'h00};
		duty_scaled = 27'(st_ff.duty) * 27'(period);
		nxt_st.pwm  = (st_ff.duty == fpl_pkg::DUTY_FULL) || (cnt_scaled < duty_scaled);
	end

	// State register
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			st_ff            <= '0;
			// R14 R6 R9 R11 reset values; R2 frequency code
			st_ff.fan_char   <= fpl_pkg::RST_FAN_CHAR;
			st_ff.floor_duty <= fpl_pkg::RST_FLOOR;
			st_ff.local_cfg  <= fpl_pkg::RST_LOCAL_CFG;
			st_ff.remote_cfg <= fpl_pkg::RST_REMOTE_CFG;
			st_ff.spin_st    <= fpl_pkg::SPIN_START;
			st_ff.strap_s1   <= 1'b1;
			st_ff.strap_s2   <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_reg_rdata     = st_ff.rdata;
	assign o_pwm           = st_ff.pwm;
	assign o_duty          = st_ff.duty;
	assign o_spinup_active = st_ff.spin_st[1]; // One-hot boost bit
	assign o_high_range    = st_ff.high_range;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	// Cycles since the last tick; reset value wraps to zero as after a tick
	logic [5:0] tb_gap;
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			tb_gap <= 6'h3F;
		end else if (st_ff.tb_tick) begin
			tb_gap <= '0;
		end else if (tb_gap != 6'h3E) begin
			tb_gap <= tb_gap + 1'b1;
		end
	end

	property p_range;
		!$past(i_reset, 1) && !$past(i_reset, 2) && !$past(i_reset, 3)
			|-> o_high_range == !$past(i_high_range_n, 3);
	endproperty
	a_range: assert property (p_range) else $error("range does not follow strap"); // R1

	property p_tb_rate;
		st_ff.tb_tick |-> (tb_gap == 6'h26 || tb_gap == 6'h27);
	endproperty
	a_tb_rate: assert property (p_tb_rate) else $error("timebase spacing wrong"); // R3

	property p_boost_full;
		st_ff.spin_st == fpl_pkg::SPIN_BOOST |=> o_duty == 8'hFF;
	endproperty
	a_boost_full: assert property (p_boost_full) else $error("no full duty in spin-up"); // R4

	property p_dis_stops;
		st_ff.fan_char[7] |=> st_ff.spin_st == fpl_pkg::SPIN_RUN;
	endproperty
	a_dis_stops: assert property (p_dis_stops) else $error("spin-up not stopped"); // R16

	property p_resets;
		$past(i_reset) |-> st_ff.fan_char == 8'h1D && st_ff.floor_duty == 8'h55
			&& st_ff.local_cfg == 8'h41 && st_ff.remote_cfg == 8'h61;
	endproperty
	a_resets: assert property (p_resets) else $error("register reset value wrong"); // R14

	property p_floor_write;
		i_reg_wr && i_reg_addr == 8'h21 |=> st_ff.floor_duty == $past(i_reg_wdata);
	endproperty
	a_floor_write: assert property (p_floor_write) else $error("floor write lost"); // R6

	property p_period_bound;
		st_ff.tb_tick && st_ff.pwm_cnt < period - 1'b1 |=> st_ff.pwm_cnt == $past(st_ff.pwm_cnt) + 1'b1;
	endproperty
	a_period_bound: assert property (p_period_bound) else $error("pwm counter stuck"); // R15

	property p_hr_default;
		st_ff.high_range && st_ff.fan_char[5:3] == 3'h3 |-> period == 19'd128;
	endproperty
	a_hr_default: assert property (p_hr_default) else $error("25 kHz period wrong"); // R2

	property p_lr_default;
		!st_ff.high_range && st_ff.fan_char[5:3] == 3'h3 |-> period == 19'h1A0AB;
	endproperty
	a_lr_default: assert property (p_lr_default) else $error("30 Hz period wrong"); // R2
endmodule

/* File: fpl_pkg.sv */
// Shared constants and types for the fan PWM temperature loop block
package fpl_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_FAN_CHAR  = 8'h20;
	localparam logic [7:0] ADDR_FLOOR     = 8'h21;
	localparam logic [7:0] ADDR_LOCAL_CFG = 8'h24;
	localparam logic [7:0] ADDR_REMOTE_CFG = 8'h25;
	// Reset values
	localparam logic [7:0] RST_FAN_CHAR   = 8'h1D;
	localparam logic [7:0] RST_FLOOR      = 8'h55;
	localparam logic [7:0] RST_LOCAL_CFG  = 8'h41;
	localparam logic [7:0] RST_REMOTE_CFG = 8'h61;
	// Field positions in the fan characteristics register
	localparam int SPINUP_DIS_BIT = 7;
	localparam int RESERVED_BIT   = 6;
	localparam int FREQ_MSB       = 5;
	localparam int FREQ_LSB       = 3;
	localparam int STIME_MSB      = 2;
	localparam int STIME_LSB      = 0;
	// Field positions in the loop registers
	localparam int THR_MSB   = 7;
	localparam int THR_LSB   = 3;
	localparam int SLOPE_MSB = 2;
	localparam int SLOPE_LSB = 0;
	localparam int DEG_PER_THR_STEP_LOG2 = 2;
	localparam logic [7:0] DUTY_FULL = 8'hFF;
	localparam logic [2:0] SLOPE_MAX_CODE = 3'h4;
	localparam logic [5:0] SLOPE_STEEPEST = 6'h20;
	localparam logic [5:0] SLOPE_GENTLEST = 6'h02;
	// Clock rates
	localparam int CORE_HZ = 125_000_000;
	localparam int TB_HZ   = 3_200_000;
	localparam int RATE_DIV = 1000;
	localparam logic [16:0] TB_STEP = 17'(TB_HZ / RATE_DIV);
	localparam logic [16:0] TB_MOD  = 17'(CORE_HZ / RATE_DIV);
	// Spin-up unit of 100 ms and its cycle count
	localparam int SPIN_UNIT_MS  = 100;
	localparam int SPIN_UNIT_CYC = (CORE_HZ / 1000) * SPIN_UNIT_MS;
	// Spin-up time per code, in 100 ms units (0.2 s .. 8 s)
	localparam logic [6:0] SPIN_UNITS [8] = '{7'h02, 7'h04, 7'h06, 7'h08,
		7'h0A, 7'h14, 7'h28, 7'h50};
	// PWM frequencies per code, in Hz
	localparam int LOW_HZ [8]  = '{10, 15, 23, 30, 38, 47, 62, 94};
	localparam int HIGH_HZ [8] = '{1000, 10000, 20000, 25000, 30000, 40000, 40000, 40000};
	localparam int PERIOD_W = 19;
	// Spin-up sequencer states
	typedef enum logic [2:0] {
		SPIN_START = 3'b001,
		SPIN_BOOST = 3'b010,
		SPIN_RUN   = 3'b100
	} fpl_spin_e;
	// Period in timebase ticks, rounded to nearest
	function automatic logic [PERIOD_W-1:0] fpl_period(input logic high, input logic [2:0] code);
		int f;
		f = high ? HIGH_HZ[code] : LOW_HZ[code];
		return PERIOD_W'((TB_HZ + f / 2) / f);
	endfunction
endpackage

/* File: fpl_loop_if.sv */
// Interface carrying one temperature loop's settings and its duty result
interface fpl_loop_if;
	logic [7:0] temp;
	logic [4:0] thr;
	logic [2:0] slope;
	logic [7:0] floor_duty;
	logic [7:0] duty;
	modport ctrl (output temp, output thr, output slope, output floor_duty, input duty);
	modport calc (input temp, input thr, input slope, input floor_duty, output duty);
endinterface

/* File: fpl_duty_calc.sv */
// Duty computation for one temperature loop
module fpl_duty_calc (
	input  wire logic   i_core_clk,
	input  wire logic   i_reset,
	fpl_loop_if.calc    lp
);
	typedef struct packed {
		logic [7:0] duty;
	} fpl_calc_s;

	fpl_calc_s st_ff;
	fpl_calc_s nxt_st;
	logic [6:0]  thr_deg;
	logic [5:0]  slope_lsb;
	logic [8:0]  diff;
	logic [14:0] raise;
	logic [15:0] sum;

	// Threshold in degrees and per-degree increment
	always_comb begin
		thr_deg = {lp.thr, 2'h0};
		// R10 R13 slope coding
		// R18 undocumented codes gentlest
		if (lp.slope <= fpl_pkg::SLOPE_MAX_CODE) begin
			slope_lsb = fpl_pkg::SLOPE_STEEPEST >> lp.slope;
		end else begin
			slope_lsb = fpl_pkg::SLOPE_GENTLEST;
		end
		diff  = {1'b0, lp.temp} - {2'h0, thr_deg};
		raise = 15'(diff) * 15'(slope_lsb);
		sum   = {8'h0, lp.floor_duty} + {1'b0, raise};
		nxt_st = st_ff;
		// R7 R12 floor at or below
		if (lp.temp <= {1'b0, thr_deg}) begin
			nxt_st.duty = lp.floor_duty;
		// R17 linear rise, saturating
		end else if (sum > {8'h0, fpl_pkg::DUTY_FULL}) begin
			nxt_st.duty = fpl_pkg::DUTY_FULL;
		end else begin
			nxt_st.duty = sum[7:0];
		end
	end

	// State register
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign lp.duty = st_ff.duty;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	property p_floor_below;
		lp.temp <= {1'b0, lp.thr, 2'h0} |=> lp.duty == $past(lp.floor_duty);
	endproperty
	a_floor_below: assert property (p_floor_below) else $error("duty not floor at low temp"); // R7

	property p_slope_step;
		lp.slope <= 3'h4 && lp.temp == {1'b0, lp.thr, 2'h0} + 8'h01 && lp.floor_duty < 8'hC0
			|=> lp.duty == $past(lp.floor_duty) + (8'h20 >> $past(lp.slope));
	endproperty
	a_slope_step: assert property (p_slope_step) else $error("slope step wrong"); // R10

	property p_slope_odd;
		lp.slope > 3'h4 && lp.temp == {1'b0, lp.thr, 2'h0} + 8'h01 && lp.floor_duty < 8'hF0
			|=> lp.duty == $past(lp.floor_duty) + 8'h02;
	endproperty
	a_slope_odd: assert property (p_slope_odd) else $error("odd slope code not 2"); // R18

	property p_saturate;
		lp.temp > {1'b0, lp.thr, 2'h0} |=> lp.duty > $past(lp.floor_duty) || lp.duty == 8'hFF;
	endproperty
	a_saturate: assert property (p_saturate) else $error("duty wrapped below floor"); // R17
endmodule

/* File: fpl_fan_model.sv */
// Fan model that measures the PWM waveform driving it
module fpl_fan_model (
	input  wire logic i_core_clk,
	input  wire logic i_pwm,
	output int        o_period,
	output int        o_high,
	output int        o_edges
);
	timeunit 1ns;
	timeprecision 1ps;
	int   cnt;
	int   hcnt;
	logic prev;
	// Clear the measurement state
	initial begin
		cnt = 0;
		hcnt = 0;
		prev = 1'b0;
		o_period = 0;
		o_high = 0;
		o_edges = 0;
	end
	// Latch period and high time at each rising edge of the drive
	always @(posedge i_core_clk) begin
		prev <= i_pwm;
		if (i_pwm && !prev) begin
			o_period <= cnt;
			o_high   <= hcnt;
			o_edges  <= o_edges + 1;
			cnt      <= 1;
			hcnt     <= 1;
		end else begin
			cnt  <= cnt + 1;
			hcnt <= hcnt + (i_pwm ? 1 : 0);
		end
	end
endmodule

/* File: fpl_top_tb.sv */
// Self-checking testbench for the fan PWM temperature loop block
module fpl_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       i_core_clk;
	logic       i_reset;
	logic       i_high_range_n;
	logic [7:0] i_local_temp;
	logic [7:0] i_remote_temp;
	logic       i_reg_wr;
	logic       i_reg_rd;
	logic [7:0] i_reg_addr;
	logic [7:0] i_reg_wdata;
	logic [7:0] o_reg_rdata;
	logic       o_pwm;
	logic [7:0] o_duty;
	logic       o_spinup_active;
	logic       o_high_range;
	int         per;
	int         hi;
	int         edges;
	int         errors;
	int         checked;
	int         n;
	int         f;
	int         tk;
	int         k;
	// Duty cases: remote select, loop config, temperature, expected duty
	logic [24:0] cases [15] = '{
		{1'b0, 8'h41, 8'd32, 8'h55}, {1'b0, 8'h41, 8'd33, 8'h65},
		{1'b0, 8'h40, 8'd35, 8'hB5}, {1'b0, 8'h42, 8'd36, 8'h75},
		{1'b0, 8'h43, 8'd34, 8'h5D}, {1'b0, 8'h44, 8'd33, 8'h57},
		{1'b0, 8'h45, 8'd34, 8'h59}, {1'b0, 8'h47, 8'd33, 8'h57},
		{1'b0, 8'h40, 8'd40, 8'hFF}, {1'b0, 8'hF8, 8'd124, 8'h55},
		{1'b0, 8'hF8, 8'd125, 8'h75}, {1'b1, 8'h61, 8'd48, 8'h55},
		{1'b1, 8'h61, 8'd49, 8'h65}, {1'b1, 8'h63, 8'd50, 8'h5D},
		{1'b1, 8'h46, 8'd37, 8'h5F}};

	fpl_top #(.P_SPIN_UNIT_CYC(50)) i_fpl_top (
		.i_core_clk     (i_core_clk),
		.i_reset        (i_reset),
		.i_high_range_n (i_high_range_n),
		.i_local_temp   (i_local_temp),
		.i_remote_temp  (i_remote_temp),
		.i_reg_wr       (i_reg_wr),
		.i_reg_rd       (i_reg_rd),
		.i_reg_addr     (i_reg_addr),
		.i_reg_wdata    (i_reg_wdata),
		.o_reg_rdata    (o_reg_rdata),
		.o_pwm          (o_pwm),
		.o_duty         (o_duty),
		.o_spinup_active(o_spinup_active),
		.o_high_range   (o_high_range)
	);
	fpl_fan_model i_fpl_fan_model (
		.i_core_clk(i_core_clk),
		.i_pwm     (o_pwm),
		.o_period  (per),
		.o_high    (hi),
		.o_edges   (edges)
	);

	// 125 MHz clock
	initial begin
		i_core_clk = 1'b0;
		forever #4 i_core_clk = ~i_core_clk;
	end

	// Compare a design value exactly
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	// Compare a measured count within a tolerance
	task automatic near(input int got, input int exp, input int tol);
		checked++;
		if (got < exp - tol || got > exp + tol) begin
			errors++;
			$display("ERROR %0t measured %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		i_reg_wr = 1'b1;
		i_reg_addr = a;
		i_reg_wdata = d;
		@(negedge i_core_clk);
		i_reg_wr = 1'b0;
		@(negedge i_core_clk);
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
		i_reg_rd = 1'b1;
		i_reg_addr = a;
		@(negedge i_core_clk);
		i_reg_rd = 1'b0;
		chk(o_reg_rdata, exp);
		@(negedge i_core_clk);
	endtask
	task automatic do_reset();
		i_reset = 1'b1;
		repeat (6) @(negedge i_core_clk);
		i_reset = 1'b0;
	endtask
	task automatic set_temps(input logic [7:0] lt, input logic [7:0] rt);
		i_local_temp = lt;
		i_remote_temp = rt;
		repeat (3) @(negedge i_core_clk);
	endtask

	// Main sequence
	initial begin
		errors = 0;
		checked = 0;
		i_reset = 1'b1;
		i_high_range_n = 1'b1;
		i_local_temp = 8'h00;
		i_remote_temp = 8'h00;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		i_reg_addr = 8'h00;
		i_reg_wdata = 8'h00;
		@(negedge i_core_clk);
		do_reset();
		@(negedge i_core_clk);
		chk(o_spinup_active, 1'b1);
		// Duty follows the boost state one cycle later
		@(negedge i_core_clk);
		chk(o_duty, 8'hFF);
		// Default spin-up code 5 is 20 units of 50 cycles
		n = 3;
		while (o_spinup_active === 1'b1 && n < 3000) begin
			@(negedge i_core_clk);
			n++;
		end
		near(n, 1000, 3);
		chk(o_high_range, 1'b0);
		reg_rd(fpl_pkg::ADDR_FAN_CHAR, 8'h1D);
		reg_rd(fpl_pkg::ADDR_FLOOR, 8'h55);
		reg_rd(fpl_pkg::ADDR_LOCAL_CFG, 8'h41);
		reg_rd(fpl_pkg::ADDR_REMOTE_CFG, 8'h61);
		reg_wr(8'h22, 8'hA5);
		reg_rd(8'h22, 8'h00);
		reg_wr(fpl_pkg::ADDR_FAN_CHAR, 8'h5D);
		reg_rd(fpl_pkg::ADDR_FAN_CHAR, 8'h1D);
		// Loop duty table, the other loop held at its floor
		foreach (cases[i]) begin
			reg_wr(cases[i][24] ? 8'h25 : 8'h24, cases[i][23:16]);
			if (cases[i][24]) begin
				set_temps(8'h00, cases[i][15:8]);
			end else begin
				set_temps(cases[i][15:8], 8'h00);
			end
			chk(o_duty, cases[i][7:0]);
		end
		reg_wr(8'h24, 8'h41);
		reg_wr(8'h25, 8'h61);
		reg_wr(fpl_pkg::ADDR_FLOOR, 8'hAA);
		reg_rd(fpl_pkg::ADDR_FLOOR, 8'hAA);
		set_temps(8'd10, 8'd10);
		chk(o_duty, 8'hAA);
		reg_wr(fpl_pkg::ADDR_FLOOR, 8'h80);
		i_high_range_n = 1'b0;
		repeat (5) @(negedge i_core_clk);
		chk(o_high_range, 1'b1);
		// Period and high time for frequency codes 1 to 7, second new edge is a full period
		for (int c = 1; c < 8; c++) begin
			reg_wr(fpl_pkg::ADDR_FAN_CHAR, {2'b00, 3'(c), 3'b101});
			f = fpl_pkg::HIGH_HZ[c];
			tk = (3200000 + f / 2) / f;
			n = edges;
			k = 0;
			while (edges < n + 2 && k < 40000) begin
				@(negedge i_core_clk);
				k++;
			end
			if (edges < n + 2) begin
				errors++;
				$display("ERROR %0t no PWM edges seen", $time);
				break;
			end
			near(per, tk * 125000 / 3200, 41);
			near(hi, tk * 62500 / 3200, 41);
		end
		// A set disable bit stops spin-up at once
		do_reset();
		reg_wr(fpl_pkg::ADDR_FAN_CHAR, 8'h9D);
		repeat (2) @(negedge i_core_clk);
		chk(o_spinup_active, 1'b0);
		// Reset brought the floor back to its reset value
		chk(o_duty, 8'h55);
		print_verdict();
	end
endmodule
